// *** inc/can_flag_pkg.sv ***
// Constants and carrier types for the CAN status and fault flag bank.
// Assumes one 50 MHz clock and a synchronous active-high reset.
// What this block does
// R1 - Driver state bit follows enable live
// R2 - Command or stuck-dominant disables driver
// R3 - Status read leaves live bits unchanged
// R4 - Receiver state bit live, command disables
// R5 - Wake receiver under command, on after reset
// R6 - Bus wake flag latches, read clears
// R7 - Overtemp flag clears when cool and read
// R8 - Receive stuck low clears after recovery, read
// R9 - Receive stuck high clears after recovery, read
// R10 - Transmit stuck dominant clears after recovery, read
// R11 - Dominant clamp clears after recovery, read
// R12 - Overcurrent clears after recovery, read
// R13 - Pending bus failure clears after recovery, read
// R14 - Confirmed bus failure clears after recovery, read
// R15 - Low line to battery clears after recovery, read
// R16 - Read during fault leaves flag set
package can_flag_pkg;

  localparam int FAULT_COUNT = 10;
  localparam logic [15:0] STATUS_READ_CMD = 16'h2180;

  localparam int F_OVERTEMP   = 0;
  localparam int F_RX_LOW     = 1;
  localparam int F_RX_HIGH    = 2;
  localparam int F_TX_DOM     = 3;
  localparam int F_DOM_CLAMP  = 4;
  localparam int F_OVERCUR    = 5;
  localparam int F_PENDING    = 6;
  localparam int F_CONFIRMED  = 7;
  localparam int F_LOW_TO_BAT = 8;
  localparam int F_WAKE       = 9;

  typedef struct packed {
    logic driverOn;
    logic receiverOn;
    logic busWakeReceiverOn;
  } live_state_t;

  typedef struct packed {
    logic busWake;
    logic lowToBattery;
    logic busFaultConfirmed;
    logic busFaultPending;
    logic overCurrent;
    logic dominantClamp;
    logic txStuckDominant;
    logic rxStuckHigh;
    logic rxStuckLow;
    logic overTemp;
  } fault_flags_t;

endpackage

// *** hw/flag_cell.sv ***
// One latched fault flag: set while condition, clear on read once condition is gone.
// Assumes condition is already synchronised to clk.
`timescale 1ns/100ps
module flag_cell #(
  parameter bit CLEAR_ON_READ_ONLY = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic condition,
  input  wire logic readStrobe,
  output logic      flag
);

  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (readStrobe && (CLEAR_ON_READ_ONLY || !condition)) begin
      flag_next = 1'b0;
    end
    if (condition) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  a_set_wins_read: assert property (@(posedge clk) disable iff (rst) // see R16
    condition |=> flag_reg)
    else $error("flag not held while condition present");

  a_clear_after_read: assert property (@(posedge clk) disable iff (rst) // see R7
    (readStrobe && !condition && !CLEAR_ON_READ_ONLY) |=> !flag_reg)
    else $error("flag not cleared by read after recovery");

endmodule // flag_cell

// *** hw/can_diag_flag_latch.sv ***
// CAN transceiver status and fault flag bank read by the microcontroller command path.
// Fault inputs come from pins or analog comparators and are synchronised here;
// command and read strobes come from logic on clk.
`timescale 1ns/100ps
module can_diag_flag_latch #(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           cmdValid,
  input  wire logic [15:0]                    cmdWord,
  input  wire logic                           rxOnlyCmd,
  input  wire logic                           sleepCmd,
  input  wire logic                           wakeRxEnableCmd,
  input  wire logic                           wakeRxDisableCmd,
  input  wire logic                           flagReadStrobe,
  input  wire logic                           busWakeIn,
  input  wire logic                           overTempIn,
  input  wire logic                           rxLowIn,
  input  wire logic                           rxHighIn,
  input  wire logic                           txDomIn,
  input  wire logic                           domClampIn,
  input  wire logic                           overCurIn,
  input  wire logic                           pendingFailIn,
  input  wire logic                           confirmedFailIn,
  input  wire logic                           lowToBatIn,
  output can_flag_pkg::live_state_t           liveState,
  output can_flag_pkg::fault_flags_t          faultFlags
);

  if (SYNC_STAGES != 3) begin : gSyncCheck
    $error("SYNC_STAGES must be 3");
  end

  localparam int N = can_flag_pkg::FAULT_COUNT;

  // Raw fault inputs in flag order
  logic [N-1:0] rawIn;
  assign rawIn[can_flag_pkg::F_OVERTEMP]   = overTempIn;
  assign rawIn[can_flag_pkg::F_RX_LOW]     = rxLowIn;
  assign rawIn[can_flag_pkg::F_RX_HIGH]    = rxHighIn;
  assign rawIn[can_flag_pkg::F_TX_DOM]     = txDomIn;
  assign rawIn[can_flag_pkg::F_DOM_CLAMP]  = domClampIn;
  assign rawIn[can_flag_pkg::F_OVERCUR]    = overCurIn;
  assign rawIn[can_flag_pkg::F_PENDING]    = pendingFailIn;
  assign rawIn[can_flag_pkg::F_CONFIRMED]  = confirmedFailIn;
  assign rawIn[can_flag_pkg::F_LOW_TO_BAT] = lowToBatIn;
  assign rawIn[can_flag_pkg::F_WAKE]       = busWakeIn;

  // Three-stage synchroniser; stage one feeds stage two only
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;
  logic [N-1:0] cond_reg;
  logic [N-1:0] s1_next;
  logic [N-1:0] s2_next;
  logic [N-1:0] s3_next;
  logic [N-1:0] cond_next;

  always_comb begin
    s1_next   = rawIn;
    s2_next   = s1_reg;
    s3_next   = s2_reg;
    cond_next = cond_reg;
    for (int i = 0; i < N; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        cond_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      cond_reg <= '0;
    end else begin
      s1_reg   <= s1_next;
      s2_reg   <= s2_next;
      s3_reg   <= s3_next;
      cond_reg <= cond_next;
    end
  end

  // Flag read clears latched flags; a live status read in the same cycle does not
  logic readHit;
  assign readHit = flagReadStrobe && !(cmdValid && cmdWord == can_flag_pkg::STATUS_READ_CMD);

  logic [N-1:0] flagBits;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gFlag
      flag_cell #(
        .CLEAR_ON_READ_ONLY (g == can_flag_pkg::F_WAKE)
      ) uCell (
        .clk        (clk),
        .rst        (rst),
        .condition  (cond_reg[g]), // see R6 see R7 see R8 see R9 see R10 see R11
        .readStrobe (readHit),     // see R12 see R13 see R14 see R15 see R16
        .flag       (flagBits[g])
      );
    end
  endgenerate

  // Live state
  logic driverOn_reg;
  logic receiverOn_reg;
  logic wakeRxOn_reg;
  logic driverOn_next;
  logic receiverOn_next;
  logic wakeRxOn_next;
  logic rxOnlyMode_reg;
  logic rxOnlyMode_next;
  logic sleepMode_reg;
  logic sleepMode_next;

  always_comb begin
    rxOnlyMode_next = rxOnlyMode_reg;
    sleepMode_next  = sleepMode_reg;
    wakeRxOn_next   = wakeRxOn_reg;
    if (rxOnlyCmd) begin
      rxOnlyMode_next = 1'b1;
    end
    if (sleepCmd) begin
      sleepMode_next = 1'b1;
    end
    if (wakeRxEnableCmd) begin // see R5
      wakeRxOn_next = 1'b1;
    end else if (wakeRxDisableCmd) begin
      wakeRxOn_next = 1'b0;
    end
    // Status read touches none of the live bits, see R3
    receiverOn_next = !sleepMode_next; // see R4
    driverOn_next   = !rxOnlyMode_next && !sleepMode_next
                      && !cond_reg[can_flag_pkg::F_TX_DOM]; // see R1 see R2
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxOnlyMode_reg <= 1'b0;
      sleepMode_reg  <= 1'b0;
      wakeRxOn_reg   <= 1'b1;
      driverOn_reg   <= 1'b1;
      receiverOn_reg <= 1'b1;
    end else begin
      rxOnlyMode_reg <= rxOnlyMode_next;
      sleepMode_reg  <= sleepMode_next;
      wakeRxOn_reg   <= wakeRxOn_next;
      driverOn_reg   <= driverOn_next;
      receiverOn_reg <= receiverOn_next;
    end
  end

  assign liveState.driverOn          = driverOn_reg;
  assign liveState.receiverOn        = receiverOn_reg;
  assign liveState.busWakeReceiverOn = wakeRxOn_reg;
  assign faultFlags = can_flag_pkg::fault_flags_t'(flagBits);

  a_driver_off_txdom: assert property (@(posedge clk) disable iff (rst) // see R2
    cond_reg[can_flag_pkg::F_TX_DOM] |=> !driverOn_reg)
    else $error("driver still on during stuck dominant");

  a_rxonly_driver: assert property (@(posedge clk) disable iff (rst) // see R1
    rxOnlyMode_reg |-> !driverOn_reg)
    else $error("driver on in receive-only mode");

  a_sleep_receiver: assert property (@(posedge clk) disable iff (rst) // see R4
    sleepCmd |=> !receiverOn_reg)
    else $error("receiver on after sleep command");

  a_wake_rx_ctrl: assert property (@(posedge clk) disable iff (rst) // see R5
    (wakeRxDisableCmd && !wakeRxEnableCmd) |=> !wakeRxOn_reg)
    else $error("wake receiver not disabled");

  a_read_keeps_live: assert property (@(posedge clk) disable iff (rst) // see R3
    (flagReadStrobe && !rxOnlyCmd && !sleepCmd && !wakeRxEnableCmd && !wakeRxDisableCmd
     && $stable(cond_reg)) |=> $stable(wakeRxOn_reg) && $stable(receiverOn_reg))
    else $error("read changed live state");

  a_wake_read_clear: assert property (@(posedge clk) disable iff (rst) // see R6
    (readHit && !cond_reg[can_flag_pkg::F_WAKE]) |=> !faultFlags.busWake)
    else $error("wake flag not cleared by read");

  a_overtemp_hold: assert property (@(posedge clk) disable iff (rst) // see R7
    cond_reg[can_flag_pkg::F_OVERTEMP] |=> faultFlags.overTemp)
    else $error("overtemp flag lost while hot");

  a_sync_delay: assert property (@(posedge clk) disable iff (rst) // see R10
    $rose(txDomIn) ##1 txDomIn [*5] |-> faultFlags.txStuckDominant)
    else $error("stuck dominant flag late");

  // Latched flags: held while the condition stands, cleared by a later read
  a_overtemp_clear: assert property (@(posedge clk) disable iff (rst) // see R7
    (readHit && !cond_reg[can_flag_pkg::F_OVERTEMP]) |=> !faultFlags.overTemp)
    else $error("overtemp flag not cleared by read");

  a_wake_set: assert property (@(posedge clk) disable iff (rst) // see R6
    cond_reg[can_flag_pkg::F_WAKE] |=> faultFlags.busWake)
    else $error("wake flag not set on bus wake");

  a_rxlow_hold: assert property (@(posedge clk) disable iff (rst) // see R8
    cond_reg[can_flag_pkg::F_RX_LOW] |=> faultFlags.rxStuckLow)
    else $error("receive low flag lost during fault");

  a_rxlow_clear: assert property (@(posedge clk) disable iff (rst) // see R8
    (readHit && !cond_reg[can_flag_pkg::F_RX_LOW]) |=> !faultFlags.rxStuckLow)
    else $error("receive low flag not cleared by read");

  a_rxhigh_hold: assert property (@(posedge clk) disable iff (rst) // see R9
    cond_reg[can_flag_pkg::F_RX_HIGH] |=> faultFlags.rxStuckHigh)
    else $error("receive high flag lost during fault");

  a_rxhigh_clear: assert property (@(posedge clk) disable iff (rst) // see R9
    (readHit && !cond_reg[can_flag_pkg::F_RX_HIGH]) |=> !faultFlags.rxStuckHigh)
    else $error("receive high flag not cleared by read");

  a_txdom_hold: assert property (@(posedge clk) disable iff (rst) // see R10
    cond_reg[can_flag_pkg::F_TX_DOM] |=> faultFlags.txStuckDominant)
    else $error("stuck dominant flag lost during fault");

  a_txdom_clear: assert property (@(posedge clk) disable iff (rst) // see R10
    (readHit && !cond_reg[can_flag_pkg::F_TX_DOM]) |=> !faultFlags.txStuckDominant)
    else $error("stuck dominant flag not cleared by read");

  a_clamp_hold: assert property (@(posedge clk) disable iff (rst) // see R11
    cond_reg[can_flag_pkg::F_DOM_CLAMP] |=> faultFlags.dominantClamp)
    else $error("dominant clamp flag lost during fault");

  a_clamp_clear: assert property (@(posedge clk) disable iff (rst) // see R11
    (readHit && !cond_reg[can_flag_pkg::F_DOM_CLAMP]) |=> !faultFlags.dominantClamp)
    else $error("dominant clamp flag not cleared by read");

  a_overcur_hold: assert property (@(posedge clk) disable iff (rst) // see R12
    cond_reg[can_flag_pkg::F_OVERCUR] |=> faultFlags.overCurrent)
    else $error("overcurrent flag lost during fault");

  a_overcur_clear: assert property (@(posedge clk) disable iff (rst) // see R12
    (readHit && !cond_reg[can_flag_pkg::F_OVERCUR]) |=> !faultFlags.overCurrent)
    else $error("overcurrent flag not cleared by read");

  a_pending_hold: assert property (@(posedge clk) disable iff (rst) // see R13
    cond_reg[can_flag_pkg::F_PENDING] |=> faultFlags.busFaultPending)
    else $error("pending failure flag lost during fault");

  a_pending_clear: assert property (@(posedge clk) disable iff (rst) // see R13
    (readHit && !cond_reg[can_flag_pkg::F_PENDING]) |=> !faultFlags.busFaultPending)
    else $error("pending failure flag not cleared by read");

  a_confirmed_hold: assert property (@(posedge clk) disable iff (rst) // see R14
    cond_reg[can_flag_pkg::F_CONFIRMED] |=> faultFlags.busFaultConfirmed)
    else $error("confirmed failure flag lost during fault");

  a_confirmed_clear: assert property (@(posedge clk) disable iff (rst) // see R14
    (readHit && !cond_reg[can_flag_pkg::F_CONFIRMED]) |=> !faultFlags.busFaultConfirmed)
    else $error("confirmed failure flag not cleared by read");

  a_lowbat_hold: assert property (@(posedge clk) disable iff (rst) // see R15
    cond_reg[can_flag_pkg::F_LOW_TO_BAT] |=> faultFlags.lowToBattery)
    else $error("low line short flag lost during fault");

  a_lowbat_clear: assert property (@(posedge clk) disable iff (rst) // see R15
    (readHit && !cond_reg[can_flag_pkg::F_LOW_TO_BAT]) |=> !faultFlags.lowToBattery)
    else $error("low line short flag not cleared by read");

  // Live state follows commands and the stuck-dominant condition; status reads and non-read cycles drop no flag
  a_driver_live: assert property (@(posedge clk) disable iff (rst) // see R1
    (!cond_reg[can_flag_pkg::F_TX_DOM] && !rxOnlyMode_reg && !sleepMode_reg
     && !rxOnlyCmd && !sleepCmd) |=> driverOn_reg)
    else $error("driver off with no cause");

  a_sleep_driver: assert property (@(posedge clk) disable iff (rst) // see R2
    sleepCmd |=> !driverOn_reg)
    else $error("driver on after sleep command");

  a_receiver_live: assert property (@(posedge clk) disable iff (rst) // see R4
    (!sleepMode_reg && !sleepCmd) |=> receiverOn_reg)
    else $error("receiver off outside sleep");

  a_wake_en_wins: assert property (@(posedge clk) disable iff (rst) // see R5
    wakeRxEnableCmd |=> wakeRxOn_reg)
    else $error("wake receiver not enabled");

  a_sleep_sticky: assert property (@(posedge clk) disable iff (rst) // see R4
    sleepMode_reg |-> !receiverOn_reg && !driverOn_reg)
    else $error("receiver or driver on in sleep");

  a_status_keeps_flags: assert property (@(posedge clk) disable iff (rst) // see R3
    (cmdValid && cmdWord == can_flag_pkg::STATUS_READ_CMD)
    |=> ($past(faultFlags) & ~faultFlags) == '0)
    else $error("status read cleared a flag");

  a_flags_need_read: assert property (@(posedge clk) disable iff (rst) // see R16
    !readHit |=> ($past(faultFlags) & ~faultFlags) == '0)
    else $error("flag dropped without a read");

  // Condition moves only where the last two stages agree
  a_sync_agree: assert property (@(posedge clk) disable iff (rst) // see R10
    1'b1 |=> (($past(s2_reg) ^ $past(s3_reg)) & (cond_reg ^ $past(cond_reg))) == '0)
    else $error("condition moved on disagreeing stages");

  a_sync_follow: assert property (@(posedge clk) disable iff (rst) // see R10
    (s2_reg == s3_reg) |=> cond_reg == $past(s3_reg))
    else $error("condition missed agreeing stages");

endmodule // can_diag_flag_latch

// *** verif/mcu_flag_reader.sv ***
// Microcontroller side: issues command words, flag reads and control pulses.
// Assumes the bench clock; drives on the falling edge, one-cycle pulses.
`timescale 1ns/100ps
module mcu_flag_reader (
  input  wire logic        clk,
  output logic             cmdValid,
  output logic [15:0]      cmdWord,
  output logic             flagReadStrobe,
  output logic [3:0]       ctrlCmd
);
  initial begin
    cmdValid = 1'b0;
    cmdWord = 16'h0000;
    flagReadStrobe = 1'b0;
    ctrlCmd = 4'h0;
  end

  // Bits of c: receive-only, sleep, wake on, wake off
  task automatic send(input logic v, input logic [15:0] w, input logic s,
                      input logic [3:0] c);
    @(negedge clk);
    cmdValid = v;
    cmdWord = w;
    flagReadStrobe = s;
    ctrlCmd = c;
    @(negedge clk);
    cmdValid = 1'b0;
    cmdWord = 16'h0000;
    flagReadStrobe = 1'b0;
    ctrlCmd = 4'h0;
  endtask

  task automatic read_flags;
    send(1'b0, 16'h0000, 1'b1, 4'h0);
  endtask

  task automatic status_read;
    send(1'b1, can_flag_pkg::STATUS_READ_CMD, 1'b1, 4'h0);
  endtask

  task automatic control(input logic [3:0] c);
    send(1'b0, 16'h0000, 1'b0, c);
  endtask
endmodule // mcu_flag_reader

// *** verif/tb_can_diag_flag_latch.sv ***
// Self-checking bench for the CAN status and fault flag bank.
// Assumes the model in mcu_flag_reader.sv and the flag package.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin badCount++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_can_diag_flag_latch;
  logic                       clk;
  logic                       rst;
  logic                       cmdValid;
  logic                       flagReadStrobe;
  logic [15:0]                cmdWord;
  logic [3:0]                 ctrl;
  logic [9:0]                 faultIn;
  can_flag_pkg::live_state_t  liveState;
  can_flag_pkg::fault_flags_t faultFlags;
  int                         badCount;
  int                         compares;

  mcu_flag_reader u_mcu (.clk(clk), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .flagReadStrobe(flagReadStrobe), .ctrlCmd(ctrl));

  can_diag_flag_latch u_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .rxOnlyCmd(ctrl[0]), .sleepCmd(ctrl[1]),
    .wakeRxEnableCmd(ctrl[2]), .wakeRxDisableCmd(ctrl[3]),
    .flagReadStrobe(flagReadStrobe),
    .busWakeIn(faultIn[can_flag_pkg::F_WAKE]),
    .overTempIn(faultIn[can_flag_pkg::F_OVERTEMP]),
    .rxLowIn(faultIn[can_flag_pkg::F_RX_LOW]),
    .rxHighIn(faultIn[can_flag_pkg::F_RX_HIGH]),
    .txDomIn(faultIn[can_flag_pkg::F_TX_DOM]),
    .domClampIn(faultIn[can_flag_pkg::F_DOM_CLAMP]),
    .overCurIn(faultIn[can_flag_pkg::F_OVERCUR]),
    .pendingFailIn(faultIn[can_flag_pkg::F_PENDING]),
    .confirmedFailIn(faultIn[can_flag_pkg::F_CONFIRMED]),
    .lowToBatIn(faultIn[can_flag_pkg::F_LOW_TO_BAT]),
    .liveState(liveState), .faultFlags(faultFlags));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200us;
    badCount++;
    finish_test();
  end

  initial begin
    badCount = 0;
    compares = 0;
    rst = 1'b1;
    faultIn = 10'h000;
    idle(2);
    rst = 1'b0;
    idle(1);
    `CHK(liveState, 3'b111)
    `CHK(faultFlags, 10'h000)
    for (int i = 0; i < 10; i++) begin
      faultIn[i] = 1'b1;
      idle(7);
      `CHK(faultFlags, 10'h001 << i)
      if (i == can_flag_pkg::F_TX_DOM) `CHK(liveState.driverOn, 1'b0)
      if (i != can_flag_pkg::F_WAKE) begin
        u_mcu.read_flags();
        idle(1);
        `CHK(faultFlags, 10'h001 << i)
      end
      faultIn[i] = 1'b0;
      idle(7);
      `CHK(liveState.driverOn, 1'b1)
      `CHK(faultFlags, 10'h001 << i)
      u_mcu.read_flags();
      idle(1);
      `CHK(faultFlags, 10'h000)
    end
    // Wake event left latched; a live status read must not clear it
    faultIn[can_flag_pkg::F_WAKE] = 1'b1;
    idle(7);
    faultIn[can_flag_pkg::F_WAKE] = 1'b0;
    idle(7);
    // Wake receiver off, then a live status read
    u_mcu.control(4'b1000);
    idle(1);
    `CHK(liveState, 3'b110)
    u_mcu.status_read();
    idle(1);
    `CHK(liveState, 3'b110)
    `CHK(faultFlags, 10'h001 << can_flag_pkg::F_WAKE)
    u_mcu.control(4'b0100);
    idle(1);
    `CHK(liveState, 3'b111)
    u_mcu.control(4'b0001);
    idle(1);
    `CHK(liveState, 3'b011)
    u_mcu.control(4'b0010);
    idle(1);
    `CHK(liveState, 3'b001)
    u_mcu.status_read();
    idle(1);
    `CHK(liveState, 3'b001)
    // Mid-run reset ends receive-only and sleep and drops the latched wake flag
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    idle(1);
    `CHK(liveState, 3'b111)
    `CHK(faultFlags, 10'h000)
    finish_test();
  end
endmodule // tb_can_diag_flag_latch
